/* File: rtl/sac_pkg.sv */
// package: register map, field layout, reset values and timing of the converter control
package sac_pkg;

   // ----------------------------------------------------------------------
   // register indices and byte addresses
   // ----------------------------------------------------------------------
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] RESULT_IDX = 12'h00D0;
   localparam logic [11:0] CTRL_IDX   = 12'h00D1;
   localparam logic [11:0] STAT_IDX   = 12'h00D8;
   localparam logic [11:0] MASK_IDX   = 12'h00D9;

   // byte address of a register index: one aligned word per register
   function automatic logic [ADDR_W-1:0] idx_addr(input logic [11:0] idx);
      idx_addr = {idx[ADDR_W-3:0], 2'b00};
   endfunction : idx_addr

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int          IRQ_EN_BIT = 7;
   localparam int          DONE_BIT   = 6;
   localparam int          GO_BIT     = 5;
   localparam int          PWR_BIT    = 4;
   localparam logic [7:0]  CTRL_RST   = 8'h0040;
   localparam int          EV_DONE    = 0;
   localparam int          EV_ABORT   = 1;
   localparam int          EV_W       = 2;
   localparam logic [1:0]  STAT_RST   = 2'h0;
   localparam logic [1:0]  MASK_RST   = 2'h0;
   localparam logic [7:0]  RESULT_RST = 8'h0000;
   localparam logic [7:0]  SAR_MSB    = 8'h0080;

   // ----------------------------------------------------------------------
   // timing: oscillator divided by twelve, about 70 us at 8 MHz
   // ----------------------------------------------------------------------
   localparam int          CONV_DIV     = 12;
   localparam int          CONV_TIME_NS = 70000;
   localparam int          REF_OSC_MHZ  = 8;
   localparam int          CONV_TICKS   =
      (CONV_TIME_NS * REF_OSC_MHZ + CONV_DIV * 1000 - 1) / (CONV_DIV * 1000);
   localparam int          BIT_TICKS    = CONV_TICKS / 8;
   localparam int          SAMPLE_TICKS = CONV_TICKS - 8 * BIT_TICKS;
   localparam logic [3:0]  DIV_LAST     = 4'(CONV_DIV - 1);
   localparam logic [5:0]  SAMPLE_LAST  = 6'(SAMPLE_TICKS - 1);
   localparam logic [5:0]  BIT_LAST     = 6'(BIT_TICKS - 1);

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_BITS} sac_state_t;

   typedef struct packed {
      logic done_irq_enable;
      logic done;
      logic converter_power_on;
   } sac_ctrl_t;

endpackage : sac_pkg

/* File: rtl/sac_top.sv */
// module: successive-approximation converter control with APB registers
`timescale 1ns/10ps
`default_nettype none

// Operation
// - go write with power bit set starts conversion, clears done
// - finished conversion sets done flag
// - go during conversion restarts at once
// - go bit always reads as zero
// - no automatic restart after completion
// - end of conversion raises maskable interrupt
// - interrupt enable bit gates the done request, not the status path
// - done flag read-only, cleared by go
// - power bit on enables, off idles converter
// - no automatic power down in wait
// - reset aborts, control 40h, irq masked
// - approximation clocked at oscillator over twelve
// - about 70us at 8MHz, 8-bit result
// - result readable read-only at 0D0h
module sac_top
   import sac_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rstn_in,
   input  wire logic              clk_en_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic              comp_in,
   output logic [7:0]             sar_code_out,
   output logic                   sample_out,
   output logic                   busy_out,
   output logic                   power_on_out,
   output logic                   irq_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic              pready_ff;
   logic              pslverr_ff;
   logic [31:0]       prdata_ff;
   logic              comp_meta_ff;
   logic              comp_sync_ff;
   sac_ctrl_t         ctrl_ff;
   logic [EV_W-1:0]   stat_ff;
   logic [EV_W-1:0]   mask_ff;
   logic [7:0]        result_ff;
   sac_state_t        state_ff;
   logic [3:0]        div_cnt_ff;
   logic [5:0]        tick_cnt_ff;
   logic [2:0]        bit_idx_ff;
   logic [7:0]        sar_ff;
   logic              sample_ff;
   logic              busy_ff;
   logic              irq_ff;

   logic              access;
   logic              wr_fire;
   logic              hit_result;
   logic              hit_ctrl;
   logic              hit_stat;
   logic              hit_mask;
   logic              mapped;
   logic              go;
   logic              tick;
   logic              bit_end;
   logic              finish;
   logic [EV_W-1:0]   events;
   logic [31:0]       nxt_rdata;

   // one approximation step: keep or drop the trial bit, set the next trial bit
   function automatic logic [7:0] sar_step(
      input logic [7:0] code,
      input logic [2:0] idx,
      input logic       keep
   );
      logic [7:0] c;
      c      = code;
      c[idx] = keep;
      if (idx != 3'h0)
      begin
         c[idx - 3'h1] = 1'b1;
      end
      sar_step = c;
   endfunction : sar_step

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   // one wait state so that read data and pready come straight from flops
   assign access     = psel_in && penable_in;
   assign wr_fire    = access && pready_ff && pwrite_in;
   assign hit_result = (paddr_in == idx_addr(RESULT_IDX));
   assign hit_ctrl   = (paddr_in == idx_addr(CTRL_IDX));
   assign hit_stat   = (paddr_in == idx_addr(STAT_IDX));
   assign hit_mask   = (paddr_in == idx_addr(MASK_IDX));
   assign mapped     = hit_result || hit_ctrl || hit_stat || hit_mask;

   // go write counts only with the power bit set in the same write; the start itself is the only trigger
   assign go = wr_fire && hit_ctrl && pwdata_in[GO_BIT]
               && pwdata_in[PWR_BIT];

   // read mux; go position always zero, reserved bits zero
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      if (hit_result)
      begin
         nxt_rdata[7:0] = result_ff;
      end
      else if (hit_ctrl)
      begin
         nxt_rdata[IRQ_EN_BIT] = ctrl_ff.done_irq_enable;
         nxt_rdata[DONE_BIT]   = ctrl_ff.done;
         nxt_rdata[GO_BIT]     = 1'b0;
         nxt_rdata[PWR_BIT]    = ctrl_ff.converter_power_on;
      end
      else if (hit_stat)
      begin
         nxt_rdata[EV_W-1:0] = stat_ff;
      end
      else if (hit_mask)
      begin
         nxt_rdata[EV_W-1:0] = mask_ff;
      end
   end

   // ----------------------------------------------------------------------
   // apb answer
   // ----------------------------------------------------------------------
   // pready rises in the second access cycle and drops right after
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else if (clk_en_in)
      begin
         pready_ff <= access && !pready_ff;
         if (access && !pready_ff)
         begin
            // unmapped address, or a write to the read-only result
            pslverr_ff <= !mapped || (pwrite_in && hit_result);
            prdata_ff  <= pwrite_in ? 32'h0000_0000 : nxt_rdata;
         end
         else
         begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // comparator synchroniser
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         comp_meta_ff <= 1'b0;
         comp_sync_ff <= 1'b0;
      end
      else if (clk_en_in)
      begin
         comp_meta_ff <= comp_in;
         comp_sync_ff <= comp_meta_ff;
      end
   end

   // ----------------------------------------------------------------------
   // conversion clock: ref clock divided by twelve
   // ----------------------------------------------------------------------
   // restarted on go so every conversion has the same tick alignment
   assign tick = (state_ff != ST_IDLE) && (div_cnt_ff == DIV_LAST);

   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         div_cnt_ff <= 4'h0;
      end
      else if (clk_en_in)
      begin
         if (go || state_ff == ST_IDLE || div_cnt_ff == DIV_LAST)
         begin
            div_cnt_ff <= 4'h0;
         end
         else
         begin
            div_cnt_ff <= div_cnt_ff + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // approximation sequencer
   // ----------------------------------------------------------------------
   assign bit_end = (state_ff == ST_BITS) && tick && (tick_cnt_ff == BIT_LAST);
   assign finish  = bit_end && (bit_idx_ff == 3'h0) && !go
                    && ctrl_ff.converter_power_on;

   // a power-off write idles the sequencer at the same edge; wait mode has no effect here
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_ff    <= ST_IDLE;
         tick_cnt_ff <= 6'h00;
         bit_idx_ff  <= 3'h7;
         sar_ff      <= 8'h0000;
         sample_ff   <= 1'b0;
         busy_ff     <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (go)
         begin
            // a running conversion is dropped and a fresh one begins
            state_ff    <= ST_SAMPLE;
            tick_cnt_ff <= 6'h00;
            bit_idx_ff  <= 3'h7;
            sar_ff      <= SAR_MSB;
            sample_ff   <= 1'b1;
            busy_ff     <= 1'b1;
         end
         else if (!ctrl_ff.converter_power_on || (wr_fire && hit_ctrl && !pwdata_in[PWR_BIT]))
         begin
            state_ff  <= ST_IDLE;
            sample_ff <= 1'b0;
            busy_ff   <= 1'b0;
         end
         else
         begin
            unique case (state_ff)
               ST_IDLE:
               begin
                  sample_ff <= 1'b0;
                  busy_ff   <= 1'b0;
               end
               ST_SAMPLE:
               begin
                  if (tick && tick_cnt_ff == SAMPLE_LAST)
                  begin
                     state_ff    <= ST_BITS;
                     tick_cnt_ff <= 6'h00;
                     sample_ff   <= 1'b0;
                  end
                  else if (tick)
                  begin
                     tick_cnt_ff <= tick_cnt_ff + 6'h01;
                  end
               end
               ST_BITS:
               begin
                  if (bit_end)
                  begin
                     // comparator high: input is at or above the trial code
                     sar_ff      <= sar_step(sar_ff, bit_idx_ff, comp_sync_ff);
                     tick_cnt_ff <= 6'h00;
                     bit_idx_ff  <= bit_idx_ff - 3'h1;
                     if (bit_idx_ff == 3'h0)
                     begin
                        state_ff <= ST_IDLE;
                        busy_ff  <= 1'b0;
                     end
                  end
                  else if (tick)
                  begin
                     tick_cnt_ff <= tick_cnt_ff + 6'h01;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // result register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         result_ff <= RESULT_RST;
      end
      else if (clk_en_in && finish)
      begin
         result_ff <= sar_step(sar_ff, 3'h0, comp_sync_ff);
      end
   end

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // done is read-only: software writes to bit 6 are ignored
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ctrl_ff.done_irq_enable    <= CTRL_RST[IRQ_EN_BIT];
         ctrl_ff.done               <= CTRL_RST[DONE_BIT];
         ctrl_ff.converter_power_on <= CTRL_RST[PWR_BIT];
      end
      else if (clk_en_in)
      begin
         if (wr_fire && hit_ctrl)
         begin
            ctrl_ff.done_irq_enable    <= pwdata_in[IRQ_EN_BIT];
            ctrl_ff.converter_power_on <= pwdata_in[PWR_BIT];
         end
         if (wr_fire && hit_ctrl && pwdata_in[GO_BIT])
         begin
            ctrl_ff.done <= 1'b0;
         end
         else if (finish)
         begin
            ctrl_ff.done <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // event status and mask
   // ----------------------------------------------------------------------
   assign events[EV_DONE]  = finish;
   assign events[EV_ABORT] = go && busy_ff;

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         stat_ff <= STAT_RST;
         mask_ff <= MASK_RST;
      end
      else if (clk_en_in)
      begin
         if (wr_fire && hit_stat)
         begin
            stat_ff <= (stat_ff & ~pwdata_in[EV_W-1:0]) | events;
         end
         else
         begin
            stat_ff <= stat_ff | events;
         end
         if (wr_fire && hit_mask)
         begin
            mask_ff <= pwdata_in[EV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------------
   // the done request stays up until a go write clears done or a control write clears the enable bit
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_ff <= 1'b0;
      end
      else if (clk_en_in)
      begin
         irq_ff <= (ctrl_ff.done && ctrl_ff.done_irq_enable)
                   || (|(stat_ff & mask_ff));
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign prdata_out   = prdata_ff;
   assign pready_out   = pready_ff;
   assign pslverr_out  = pslverr_ff;
   assign sar_code_out = sar_ff;
   assign sample_out   = sample_ff;
   assign busy_out     = busy_ff;
   assign power_on_out = ctrl_ff.converter_power_on;
   assign irq_out      = irq_ff;

endmodule : sac_top

`default_nettype wire

/* File: testbench/sac_top_properties.sv */
// checker: bus, conversion and interrupt properties of the converter control
`timescale 1ns/10ps
`default_nettype none
module sac_top_properties
   import sac_pkg::*;
(
   input wire logic              ref_clk_in,
   input wire logic              rstn_in,
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0]       pwdata_in,
   input wire logic [31:0]       prdata_out,
   input wire logic              pready_out,
   input wire logic              pslverr_out,
   input wire logic [7:0]        sar_code_out,
   input wire logic              sample_out,
   input wire logic              busy_out,
   input wire logic              power_on_out,
   input wire logic              irq_out
);
   // byte addresses are four times the register index
   localparam logic [11:0] A_RES = 12'h340;
   localparam logic [11:0] A_CTL = 12'h344;

   logic        ctl_wr;
   logic        go_wr;
   logic [11:0] busy_cnt;

   // ----------------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------------
   // a control write counts only at the edge that samples pready
   assign ctl_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == A_CTL;
   assign go_wr  = ctl_wr && pwdata_in[GO_BIT] && pwdata_in[PWR_BIT];

   // cycles since the last start; a restart begins the count again
   always_ff @(posedge ref_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         busy_cnt <= '0;
      else if (go_wr)
         busy_cnt <= '0;
      else if (busy_out)
         busy_cnt <= busy_cnt + 12'h001;
   end

   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_go;
      go_wr;
   endsequence
   sequence s_begin;
      busy_out && sample_out && sar_code_out == SAR_MSB;
   endsequence

   chk_go_starts: assert property (s_go |=> s_begin)
      else $error("start write did not begin a conversion");
   chk_no_restart: assert property (!busy_out && !go_wr |=> !busy_out)
      else $error("conversion began without a start write");
   chk_go_reads_zero: assert property (pready_out && !pwrite_in && paddr_in == A_CTL
      |-> !prdata_out[GO_BIT])
      else $error("start bit read back as one");
   chk_power_follows: assert property (ctl_wr |=> power_on_out == $past(pwdata_in[PWR_BIT]))
      else $error("power output does not follow the written bit");
   chk_power_idle: assert property (!power_on_out |-> !busy_out)
      else $error("converting while powered down");
   chk_conv_length: assert property ($fell(busy_out) && power_on_out
      |-> busy_cnt inside {[12'h22C:12'h23C]})
      else $error("conversion length off the divided clock count");
   chk_irq_quiet: assert property ($rose(busy_out) |=> !irq_out)
      else $error("interrupt still pending after a start");
   chk_result_ro: assert property (pready_out && pwrite_in && paddr_in == A_RES
      |-> pslverr_out)
      else $error("write to result register not refused");
endmodule : sac_top_properties

bind sac_top sac_top_properties chk_u (.ref_clk_in, .rstn_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .sar_code_out, .sample_out, .busy_out, .power_on_out, .irq_out);
`default_nettype wire

/* File: testbench/sar_adc_control_test.sv */
// testbench: register-level checks of the converter control over APB
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module sar_adc_control_test
   import sac_pkg::*;
;
   localparam logic [11:0] A_RES = 12'h340;
   localparam logic [11:0] A_CTL = 12'h344;
   localparam logic [11:0] A_STS = 12'h360;
   localparam logic [11:0] A_MSK = 12'h364;
   localparam logic [11:0] A_BAD = 12'h3FC;

   logic        ref_clk, rstn, psel, penable, pwrite, comp, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdata;
   logic [7:0]  target;
   logic [7:0]  targets [3] = '{8'h00, 8'hFF, 8'hA5};
   wire  logic [31:0] prdata;
   wire  logic [7:0]  sar_code;
   wire  logic        pready, pslverr, sample, busy, pwr_on, irq;
   int          n_mismatch, comparisons;

   sac_top dut_u (.ref_clk_in(ref_clk), .rstn_in(rstn), .clk_en_in(1'b1), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .comp_in(comp),
      .sar_code_out(sar_code), .sample_out(sample), .busy_out(busy),
      .power_on_out(pwr_on), .irq_out(irq));

   // ----------------------------------------------------------------------
   // clock and analog side
   // ----------------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ideal comparator: input level is the target code
   always @(posedge ref_clk)
      comp <= (target >= sar_code);

   // ----------------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------------
   task automatic tally_and_finish;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // one transfer; an idle cycle follows so psel is never driven twice at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      @(posedge ref_clk);
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, rdata)
   endtask : rd_chk

   // bounded wait for the end of a conversion, plus the interrupt's one-cycle lag
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2000)
      begin
         @(posedge ref_clk);
         k++;
      end
      if (k >= 2000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
      repeat (2) @(posedge ref_clk);
   endtask : wait_idle

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      {rstn, psel, penable, pwrite} = '0;
      paddr = '0;
      pwdata = '0;
      target = '0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd_chk(A_CTL, 32'h0000_0040, "ctrl reset");
      rd_chk(A_RES, 32'h0000_0000, "result reset");
      rd_chk(A_STS, 32'h0000_0000, "status reset");
      rd_chk(A_MSK, 32'h0000_0000, "mask reset");
      `CHK("irq reset", 1'b0, irq)
      apb(1'b1, A_CTL, 32'h0000_0010);
      `CHK("power on", 1'b1, pwr_on)
      rd_chk(A_CTL, 32'h0000_0050, "ctrl powered");
      // boundary codes and A5h, each started by its own write
      foreach (targets[i])
      begin
         target <= targets[i];
         apb(1'b1, A_CTL, 32'h0000_00B0);
         `CHK("busy after go", 1'b1, busy)
         rd_chk(A_CTL, 32'h0000_0090, "ctrl running");
         wait_idle();
         rd_chk(A_RES, {24'h00_0000, targets[i]}, "result");
         rd_chk(A_CTL, 32'h0000_00D0, "ctrl done");
         `CHK("irq done", 1'b1, irq)
      end
      repeat (600) @(posedge ref_clk);
      `CHK("no auto restart", 1'b0, busy)
      rd_chk(A_CTL, 32'h0000_00D0, "done held");
      apb(1'b1, A_CTL, 32'h0000_0010);
      @(posedge ref_clk);
      `CHK("irq disabled", 1'b0, irq)
      rd_chk(A_STS, 32'h0000_0001, "status done");
      apb(1'b1, A_STS, 32'h0000_0001);
      rd_chk(A_STS, 32'h0000_0000, "status cleared");
      // restart in mid conversion
      apb(1'b1, A_CTL, 32'h0000_0030);
      repeat (100) @(posedge ref_clk);
      apb(1'b1, A_CTL, 32'h0000_0030);
      `CHK("busy on restart", 1'b1, busy)
      wait_idle();
      rd_chk(A_STS, 32'h0000_0003, "status abort and done");
      `CHK("irq gated", 1'b0, irq)
      apb(1'b1, A_MSK, 32'h0000_0001);
      @(posedge ref_clk);
      `CHK("irq via mask", 1'b1, irq)
      apb(1'b1, A_STS, 32'h0000_0001);
      @(posedge ref_clk);
      `CHK("irq cleared", 1'b0, irq)
      rd_chk(A_STS, 32'h0000_0002, "status abort left");
      apb(1'b1, A_MSK, 32'h0000_0000);
      apb(1'b1, A_STS, 32'h0000_0002);
      // power down in mid conversion
      apb(1'b1, A_CTL, 32'h0000_0030);
      repeat (50) @(posedge ref_clk);
      apb(1'b1, A_CTL, 32'h0000_0000);
      `CHK("busy power off", 1'b0, busy)
      rd_chk(A_CTL, 32'h0000_0000, "ctrl off");
      rd_chk(A_STS, 32'h0000_0000, "no event on power off");
      // refused accesses
      apb(1'b1, A_RES, 32'h0000_0077);
      `CHK("result write refused", 1'b1, rerr)
      rd_chk(A_RES, 32'h0000_00A5, "result kept");
      apb(1'b0, A_BAD, 32'h0000_0000);
      `CHK("unmapped refused", 1'b1, rerr)
      // reset in mid conversion
      apb(1'b1, A_CTL, 32'h0000_00B0);
      repeat (50) @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK("busy after reset", 1'b0, busy)
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd_chk(A_CTL, 32'h0000_0040, "ctrl after reset");
      `CHK("irq after reset", 1'b0, irq)
      // start bit without power: done clears, nothing starts
      apb(1'b1, A_CTL, 32'h0000_0020);
      `CHK("no start unpowered", 1'b0, busy)
      rd_chk(A_CTL, 32'h0000_0000, "done cleared unpowered");
      tally_and_finish();
   end
endmodule : sar_adc_control_test
`default_nettype wire
